// >>> design/cts_pkg.sv
package cts_pkg;

    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 8;

    // printed management indices; byte address is four times the index
    localparam int IDX_STATUS = 8'h1B;
    localparam int IDX_TUNING = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(4 * IDX_STATUS);
    localparam logic [ADDR_W-1:0] ADDR_TUNING = ADDR_W'(4 * IDX_TUNING);

    localparam int TUN_EDGE_RATE = 4;
    localparam int TUN_FSENSE_DIS = 3;
    localparam int TUN_FEF_DIS = 2;
    localparam int TUN_BACKUP_DIS = 1;
    localparam logic [15:0] TUNING_RESET = 16'h0000;

    localparam int ST_SEED_LOST = 10;
    localparam int ST_LINK_UP = 9;
    localparam int ST_COPPER_PKT = 5;
    localparam int ST_FIBER_PKT = 1;

    // vco frequency check: vco arrives divided, counted over a window
    localparam int FREQ_LOW_MHZ = 122;
    localparam int FREQ_HIGH_MHZ = 128;
    localparam int VCO_DIV = 16;
    localparam int FREQ_WIN_CYC = 1600;
    localparam int FREQ_LOW_CNT = FREQ_LOW_MHZ * FREQ_WIN_CYC
                                  / (CLK_MHZ * VCO_DIV);
    localparam int FREQ_HIGH_CNT = FREQ_HIGH_MHZ * FREQ_WIN_CYC
                                   / (CLK_MHZ * VCO_DIV);
    localparam int WIN_W = 11;
    localparam int EDGE_W = 9;

    // least seed silence, rounded up to whole cycles
    localparam int SEED_TIMEOUT_NS = 1300000;
    localparam int SEED_TIMEOUT_CYC = (SEED_TIMEOUT_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int SEED_CNT_W = 24;

    typedef struct packed {
        logic fiber_pll_on_local_osc;
        logic fiber_freq_out_of_range;
        logic far_fault_seen;
        logic copper_pll_on_local_osc;
        logic copper_freq_out_of_range;
        logic descrambler_seed_lost;
        logic copper_link_up;
        logic autoneg_done;
        logic copper_fast_signal_seen;
        logic copper_slow_signal_seen;
        logic copper_packet_seen;
        logic copper_burst_seen;
        logic fiber_fast_signal_seen;
        logic fiber_slow_signal_seen;
        logic fiber_packet_seen;
        logic fiber_negotiation_burst_seen;
    } cts_status_t;

    // raw line indications; index 0 is fiber, 1 is copper
    typedef struct packed {
        logic [1:0] pll_on_local_osc;
        logic [1:0] filter_reset;
        logic [1:0] vco_div;
        logic far_fault_pattern;
        logic descrambler_enabled;
        logic seed_update;
        logic copper_link_live;
        logic autoneg_live;
        logic transparent_mode;
        logic copper_fast;
        logic copper_slow;
        logic copper_packet_active;
        logic copper_flp_burst;
        logic copper_fiber_negotiation_burst_seen_burst;
        logic copper_pecl_mode;
        logic fiber_fast;
        logic fiber_slow;
        logic fiber_packet_active;
        logic fiber_fiber_negotiation_burst_seen_burst;
        logic backup_link_strap;
    } cts_pins_t;

    typedef struct packed {
        logic tp_edge_rate_select;
        logic freq_sense_disable;
        logic far_fault_gen_enable;
        logic far_fault_detect_enable;
        logic backup_link_enable;
    } cts_ctrl_t;

    typedef struct packed {
        cts_pins_t s1;
        cts_pins_t s2;
        cts_pins_t s3;
        logic [15:0] tuning;
        logic [15:0] rdata;
        logic [SEED_CNT_W-1:0] seed_cnt;
        logic [WIN_W-1:0] win_cnt;
        logic [1:0][EDGE_W-1:0] edge_cnt;
        logic [1:0] bad;
        logic seed_lat;
        logic link_lat;
        logic cpkt_lat;
        logic fpkt_lat;
    } cts_state_t;

endpackage : cts_pkg

// >>> design/cts_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cts_regs #(
    parameter int unsigned SEED_TIMEOUT_CYC = cts_pkg::SEED_TIMEOUT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cts_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cts_pkg::cts_pins_t pins,
    output cts_pkg::cts_ctrl_t ctrl,
    output cts_pkg::cts_status_t status
);

    localparam logic [cts_pkg::SEED_CNT_W-1:0] SEED_LIMIT =
        cts_pkg::SEED_CNT_W'(SEED_TIMEOUT_CYC);
    localparam logic [cts_pkg::EDGE_W-1:0] LOW_CNT =
        cts_pkg::EDGE_W'(cts_pkg::FREQ_LOW_CNT);
    localparam logic [cts_pkg::EDGE_W-1:0] HIGH_CNT =
        cts_pkg::EDGE_W'(cts_pkg::FREQ_HIGH_CNT);
    localparam logic [cts_pkg::WIN_W-1:0] WIN_LAST =
        cts_pkg::WIN_W'(cts_pkg::FREQ_WIN_CYC - 1);

    cts_pkg::cts_state_t q_r;
    cts_pkg::cts_state_t q_nxt;

    logic hit_status;
    logic hit_tuning;
    logic setup;
    logic access;
    logic rd_done;
    logic wr_done;
    logic fsd;
    logic transp;
    logic c_active;
    logic f_active;
    logic c_pkt_ev;
    logic f_pkt_ev;
    logic seed_ev;
    logic seed_live;
    logic win_end;

    // address decode
    always_comb begin
        hit_status = 1'b0;
        hit_tuning = 1'b0;
        if (paddr == cts_pkg::ADDR_STATUS) begin
            hit_status = 1'b1;
        end else if (paddr == cts_pkg::ADDR_TUNING) begin
            hit_tuning = 1'b1;
        end
    end

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign rd_done = access & ~pwrite & hit_status;
    assign wr_done = access & pwrite & hit_tuning;
    assign pready = 1'b1;
    assign pslverr = access & ~hit_status & ~hit_tuning;
    assign prdata = {16'h0000, q_r.rdata};

    assign fsd = q_r.tuning[cts_pkg::TUN_FSENSE_DIS];
    assign transp = q_r.s2.transparent_mode;
    assign c_active = q_r.s2.copper_fast | q_r.s2.copper_slow;
    assign f_active = q_r.s2.fiber_fast | q_r.s2.fiber_slow;
    assign c_pkt_ev = q_r.s2.copper_packet_active
                      & ~q_r.s3.copper_packet_active;
    assign f_pkt_ev = q_r.s2.fiber_packet_active
                      & ~q_r.s3.fiber_packet_active;
    assign seed_ev = q_r.s2.seed_update & ~q_r.s3.seed_update;
    assign seed_live = q_r.seed_cnt >= SEED_LIMIT;
    assign win_end = q_r.win_cnt == WIN_LAST;

    assign ctrl.tp_edge_rate_select =
        q_r.tuning[cts_pkg::TUN_EDGE_RATE];
    assign ctrl.freq_sense_disable = fsd;
    assign ctrl.far_fault_gen_enable =
        ~q_r.tuning[cts_pkg::TUN_FEF_DIS];
    assign ctrl.far_fault_detect_enable =
        ~q_r.tuning[cts_pkg::TUN_FEF_DIS];
    assign ctrl.backup_link_enable = q_r.s2.backup_link_strap
        & ~q_r.tuning[cts_pkg::TUN_BACKUP_DIS];

    // live view of the status word
    always_comb begin
        status.fiber_pll_on_local_osc = q_r.s2.pll_on_local_osc[0];
        status.fiber_freq_out_of_range = q_r.bad[0];
        status.far_fault_seen = q_r.s2.far_fault_pattern
            & ~q_r.tuning[cts_pkg::TUN_FEF_DIS];
        status.copper_pll_on_local_osc = q_r.s2.pll_on_local_osc[1];
        status.copper_freq_out_of_range = q_r.bad[1];
        status.descrambler_seed_lost = q_r.seed_lat;
        status.copper_link_up = q_r.link_lat & ~transp;
        status.autoneg_done = q_r.s2.autoneg_live & ~transp;
        status.copper_fast_signal_seen = q_r.s2.copper_fast;
        status.copper_slow_signal_seen = q_r.s2.copper_slow;
        status.copper_packet_seen = q_r.cpkt_lat & c_active;
        status.copper_burst_seen = q_r.s2.copper_flp_burst
            | (q_r.s2.copper_pecl_mode & q_r.s2.copper_fiber_negotiation_burst_seen_burst);
        status.fiber_fast_signal_seen = q_r.s2.fiber_fast;
        status.fiber_slow_signal_seen = q_r.s2.fiber_slow;
        status.fiber_packet_seen = q_r.fpkt_lat & f_active;
        status.fiber_negotiation_burst_seen =
            q_r.s2.fiber_fiber_negotiation_burst_seen_burst;
    end

    always_comb begin
        q_nxt = q_r;
        // all line inputs are asynchronous: two stages, third for edges
        q_nxt.s1 = pins;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;

        if (wr_done) begin
            q_nxt.tuning = pwdata[15:0];
        end

        // data is captured in setup so prdata comes from a flop
        if (setup) begin
            if (hit_status) begin
                q_nxt.rdata = status;
            end else if (hit_tuning) begin
                q_nxt.rdata = q_r.tuning;
            end else begin
                q_nxt.rdata = 16'h0000;
            end
        end

        // seed watchdog
        if (!q_r.s2.descrambler_enabled || seed_ev) begin
            q_nxt.seed_cnt = '0;
        end else if (!seed_live) begin
            q_nxt.seed_cnt = q_r.seed_cnt + 1'b1;
        end

        // only bits actually returned are released; an event landing
        // between capture and completion survives the read
        if (rd_done && q_r.rdata[cts_pkg::ST_SEED_LOST]) begin
            q_nxt.seed_lat = seed_live;
        end else begin
            q_nxt.seed_lat = q_r.seed_lat | seed_live;
        end

        if (rd_done && !q_r.rdata[cts_pkg::ST_LINK_UP]) begin
            q_nxt.link_lat = q_r.s2.copper_link_live;
        end else begin
            q_nxt.link_lat = q_r.link_lat
                             & q_r.s2.copper_link_live;
        end

        if (!c_active) begin
            q_nxt.cpkt_lat = 1'b0;
        end else if (rd_done && q_r.rdata[cts_pkg::ST_COPPER_PKT]) begin
            q_nxt.cpkt_lat = c_pkt_ev;
        end else begin
            q_nxt.cpkt_lat = q_r.cpkt_lat | c_pkt_ev;
        end

        if (!f_active) begin
            q_nxt.fpkt_lat = 1'b0;
        end else if (rd_done && q_r.rdata[cts_pkg::ST_FIBER_PKT]) begin
            q_nxt.fpkt_lat = f_pkt_ev;
        end else begin
            q_nxt.fpkt_lat = q_r.fpkt_lat | f_pkt_ev;
        end

        // frequency window shared by both plls
        q_nxt.win_cnt = win_end ? '0 : q_r.win_cnt + 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            if (fsd || q_r.s2.filter_reset[ch]) begin
                q_nxt.edge_cnt[ch] = '0;
                q_nxt.bad[ch] = 1'b0;
            end else if (win_end) begin
                q_nxt.edge_cnt[ch] = '0;
                q_nxt.bad[ch] = (q_r.edge_cnt[ch] < LOW_CNT)
                    || (q_r.edge_cnt[ch] > HIGH_CNT);
            end else if (q_r.s2.vco_div[ch] && !q_r.s3.vco_div[ch]
                         && !(&q_r.edge_cnt[ch])) begin
                q_nxt.edge_cnt[ch] = q_r.edge_cnt[ch] + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
            q_r.tuning <= cts_pkg::TUNING_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_EDGE_RATE_WRITE: assert property (
        wr_done |=> ctrl.tp_edge_rate_select
                    == $past(pwdata[cts_pkg::TUN_EDGE_RATE]))
        else $error("edge rate select did not follow write");

    AST_FSENSE_CLEARS_BAD: assert property (
        fsd |=> q_r.bad == 2'b00 && !status.fiber_freq_out_of_range
                && !status.copper_freq_out_of_range)
        else $error("bad frequency shown while sensing disabled");

    AST_FEF_MASK: assert property (
        q_r.tuning[cts_pkg::TUN_FEF_DIS] |->
            !status.far_fault_seen && !ctrl.far_fault_gen_enable)
        else $error("far fault active while disabled");

    AST_BACKUP_OVERRIDE: assert property (
        q_r.tuning[cts_pkg::TUN_BACKUP_DIS] |-> !ctrl.backup_link_enable)
        else $error("backup link enabled against disable bit");

    AST_TUNING_READBACK: assert property (
        wr_done ##1 !wr_done ##1 (setup && hit_tuning)
            |=> q_r.rdata == $past(pwdata[15:0], 3))
        else $error("tuning readback differs from write");

    AST_SEED_SETS: assert property (
        (q_r.s2.descrambler_enabled && !seed_ev
         && q_r.seed_cnt == SEED_LIMIT - 1'b1) |=> ##1 q_r.seed_lat)
        else $error("seed loss not latched at timeout");

    AST_LINK_LATCH_LOW: assert property (
        (!q_r.s2.copper_link_live && !rd_done)
            |=> !q_r.link_lat ##1 (!q_r.link_lat || $past(rd_done)))
        else $error("link drop not held until read");

    AST_PKT_FORCED_LOW: assert property (
        !c_active |-> !status.copper_packet_seen)
        else $error("copper packet flag with no signal");

    AST_TRANSPARENT_ZERO: assert property (
        transp |-> !status.autoneg_done && !status.copper_link_up)
        else $error("negotiation status shown in transparent mode");

    AST_READ_RELOAD: assert property (
        (rd_done && q_r.rdata[cts_pkg::ST_FIBER_PKT] && !f_pkt_ev)
            |=> !q_r.fpkt_lat)
        else $error("fiber packet latch not reloaded by read");

    AST_FREQ_LOW: assert property (
        (win_end && !fsd && !q_r.s2.filter_reset[0]
         && q_r.edge_cnt[0] < LOW_CNT) |=> q_r.bad[0])
        else $error("slow fiber vco not flagged");

    AST_FREQ_HIGH: assert property (
        (win_end && !fsd && !q_r.s2.filter_reset[1]
         && q_r.edge_cnt[1] > HIGH_CNT) |=> q_r.bad[1])
        else $error("fast copper vco not flagged");

    AST_FILTER_RESET_CLEARS: assert property (
        q_r.s2.filter_reset[0] |=> !q_r.bad[0])
        else $error("fiber bad frequency shown during filter reset");

    AST_SENSE_DISABLE_WRITE: assert property (
        wr_done |=> ctrl.freq_sense_disable
                    == $past(pwdata[cts_pkg::TUN_FSENSE_DIS]))
        else $error("sense disable did not follow write");

    AST_WRITE_LANDS: assert property (
        wr_done |=> q_r.tuning == $past(pwdata[15:0]))
        else $error("tuning write did not land");

    AST_SEED_HOLD: assert property (
        q_r.seed_lat && !rd_done |=> q_r.seed_lat)
        else $error("seed loss dropped before read");

    AST_COPPER_PKT_SET: assert property (
        c_active && c_pkt_ev |=> q_r.cpkt_lat)
        else $error("copper packet not latched");

    AST_FIBER_PKT_SET: assert property (
        f_active && f_pkt_ev |=> q_r.fpkt_lat)
        else $error("fiber packet not latched");

    AST_FIBER_PKT_FORCED_LOW: assert property (
        !f_active |-> !status.fiber_packet_seen)
        else $error("fiber packet flag with no signal");

    // two flops from pin to status: checked against the pin itself
    AST_FIBER_LOCAL_OSC: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.fiber_pll_on_local_osc
            == $past(pins.pll_on_local_osc[0], 2))
        else $error("fiber local oscillator flag wrong");

    AST_COPPER_LOCAL_OSC: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.copper_pll_on_local_osc
            == $past(pins.pll_on_local_osc[1], 2))
        else $error("copper local oscillator flag wrong");

    AST_FAR_FAULT_SEEN: assert property (
        $past(presetn) && $past(presetn, 2)
            && !q_r.tuning[cts_pkg::TUN_FEF_DIS] |->
            status.far_fault_seen == $past(pins.far_fault_pattern, 2))
        else $error("far fault flag does not follow the line");

    AST_COPPER_FAST: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.copper_fast_signal_seen == $past(pins.copper_fast, 2))
        else $error("copper fast signal flag wrong");

    AST_COPPER_SLOW: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.copper_slow_signal_seen == $past(pins.copper_slow, 2))
        else $error("copper slow signal flag wrong");

    AST_FIBER_FAST: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.fiber_fast_signal_seen == $past(pins.fiber_fast, 2))
        else $error("fiber fast signal flag wrong");

    AST_FIBER_SLOW: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.fiber_slow_signal_seen == $past(pins.fiber_slow, 2))
        else $error("fiber slow signal flag wrong");

    AST_FIBER_BURST: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.fiber_negotiation_burst_seen
            == $past(pins.fiber_fiber_negotiation_burst_seen_burst, 2))
        else $error("fiber burst flag wrong");

    AST_COPPER_BURST: assert property (
        $past(presetn) && $past(presetn, 2) |->
            status.copper_burst_seen == ($past(pins.copper_flp_burst, 2)
            || ($past(pins.copper_pecl_mode, 2)
                && $past(pins.copper_fiber_negotiation_burst_seen_burst, 2))))
        else $error("copper burst flag wrong");

    COV_SEED_LOST: cover property (
        rd_done && q_r.rdata[cts_pkg::ST_SEED_LOST]);
    COV_TUNING_WRITE: cover property (wr_done ##[1:4] rd_done);
    COV_BAD_FREQ: cover property ($rose(q_r.bad[1]));
    COV_PKT_READ: cover property (c_pkt_ev ##[1:20] rd_done);

endmodule : cts_regs

// >>> tb/cts_host_model.sv
`timescale 1ns/1ps
// apb master standing in for the management host
module cts_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [cts_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // idle edge first: psel never drops and rises in one step
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : cts_host_model

// >>> tb/cts_regs_tb_top.sv
`timescale 1ns/1ps
module cts_regs_tb_top;
    localparam logic [7:0] AT = cts_pkg::ADDR_TUNING;
    localparam logic [7:0] AS = cts_pkg::ADDR_STATUS;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, vco;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    cts_pkg::cts_pins_t pv, pins;
    cts_pkg::cts_ctrl_t ctrl;
    cts_pkg::cts_status_t status;
    int failures, num_checks, cycles, vper, vcnt;

    cts_regs #(.SEED_TIMEOUT_CYC(50)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .ctrl(ctrl), .status(status));
    cts_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // divided vco stand-in; 1600/vper rising edges per window
    always @(posedge pclk) begin
        vcnt <= (vcnt + 1 >= vper) ? 0 : vcnt + 1;
        vco <= (vcnt < vper / 2);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    always_comb begin
        pins = pv;
        pins.vco_div = {2{vco}};
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        host.xfer(1'b0, a, 32'h0, d, e);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        host.xfer(1'b1, a, d, x, e);
    endtask : wr

    task automatic sm(input string n, input logic [15:0] m,
        input logic [15:0] e);
        chk(n, {16'h0, e}, {16'h0, status & m});
    endtask : sm

    task automatic see(input logic [15:0] e);
        cyc(4);
        sm("status", 16'hFFFF, e);
    endtask : see

    function automatic logic [4:0] cexp(logic [15:0] t, logic s);
        return {t[4], t[3], ~t[2], ~t[2], s & ~t[1]};
    endfunction : cexp

    task automatic t_reset();
        rd(AT, q);
        chk("tuning", 32'h0, q);
        rd(AS, q);
        chk("status", 32'h0, q);
        chk("ctrl", {27'h0, cexp(16'h0, 1'b0)}, {27'h0, ctrl});
        chk("pready", 32'h1, {31'h0, pready});
        $display("test reset done");
    endtask : t_reset

    task automatic t_tuning();
        logic e;
        logic [15:0] t;
        pv.backup_link_strap <= 1'b1;
        for (int i = 1; i < 5; i++) begin
            t = 16'h1 << i;
            wr(AT, {16'h0, t});
            rd(AT, q);
            chk("tuning", {16'h0, t}, q);
            chk("ctrl", {27'h0, cexp(t, 1'b1)},
                {27'h0, ctrl});
        end
        wr(AT, 32'h0000FFFF);
        host.xfer(1'b1, 8'h74, 32'h0, q, e);
        chk("slverr", 32'h1, {31'h0, e});
        rd(AT, q);
        chk("tuning", 32'h0000FFFF, q);
        chk("ctrl", {27'h0, cexp(16'hFFFF, 1'b1)}, {27'h0, ctrl});
        host.xfer(1'b0, 8'h74, 32'h0, q, e);
        chk("unmapped", 32'h0, q);
        wr(AT, 32'h0);
        $display("test tuning done");
    endtask : t_tuning

    // bits are set or cleared one at a time, apart from the copper burst swap and the final clear, so each step isolates one bit
    task automatic t_live();
        pv.pll_on_local_osc <= 2'h1;
        see(16'h8000);
        pv.pll_on_local_osc <= 2'h3;
        see(16'h9000);
        pv.far_fault_pattern <= 1'b1;
        see(16'hB000);
        pv.autoneg_live <= 1'b1;
        see(16'hB100);
        pv.copper_fast <= 1'b1;
        see(16'hB180);
        pv.copper_slow <= 1'b1;
        see(16'hB1C0);
        pv.copper_flp_burst <= 1'b1;
        see(16'hB1D0);
        pv.fiber_fast <= 1'b1;
        see(16'hB1D8);
        pv.fiber_slow <= 1'b1;
        see(16'hB1DC);
        pv.fiber_fiber_negotiation_burst_seen_burst <= 1'b1;
        see(16'hB1DD);
        pv.transparent_mode <= 1'b1;
        see(16'hB0DD);
        wr(AT, 32'h4);
        see(16'h90DD);
        pv.copper_flp_burst <= 1'b0;
        pv.copper_fiber_negotiation_burst_seen_burst <= 1'b1;
        see(16'h90CD);
        pv.copper_pecl_mode <= 1'b1;
        see(16'h90DD);
        wr(AT, 32'h0);
        pv <= '0;
        see(16'h0000);
        $display("test live done");
    endtask : t_live

    task automatic pkt();
        pv.copper_packet_active <= 1'b1;
        pv.fiber_packet_active <= 1'b1;
        cyc(1);
        pv.copper_packet_active <= 1'b0;
        pv.fiber_packet_active <= 1'b0;
        cyc(4);
    endtask : pkt

    task automatic t_latch();
        pv.copper_fast <= 1'b1;
        pv.fiber_fast <= 1'b1;
        cyc(4);
        pkt();
        sm("pkt", 16'h0022, 16'h0022);
        rd(AS, q);
        chk("pkt", 32'h22, q & 32'h22);
        rd(AS, q);
        chk("pkt", 32'h0, q & 32'h22);
        pkt();
        pv.copper_fast <= 1'b0;
        pv.fiber_fast <= 1'b0;
        see(16'h0000);
        for (int i = 0; i < 2; i++) begin
            pv.copper_link_live <= 1'b0;
            cyc(2);
            pv.copper_link_live <= 1'b1;
            cyc(4);
            rd(AS, q);
            chk("link", 32'h0, {31'h0, q[9]});
            rd(AS, q);
            chk("link", 32'h1, {31'h0, q[9]});
        end
        pv.transparent_mode <= 1'b1;
        see(16'h0000);
        pv <= '0;
        $display("test latch done");
    endtask : t_latch

    task automatic t_seed();
        pv.descrambler_enabled <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            pv.seed_update <= 1'b1;
            cyc(1);
            pv.seed_update <= 1'b0;
            cyc(40);
            sm("seed", 16'h0400, i ? 16'h0400 : 16'h0);
            cyc(40);
            sm("seed", 16'h0400, 16'h0400);
        end
        pv.seed_update <= 1'b1;
        cyc(1);
        pv.seed_update <= 1'b0;
        cyc(5);
        sm("seed", 16'h0400, 16'h0400);
        rd(AS, q);
        chk("seed", 32'h400, q & 32'h400);
        rd(AS, q);
        chk("seed", 32'h0, q & 32'h400);
        pv <= '0;
        $display("test seed done");
    endtask : t_seed

    task automatic t_freq();
        vper <= 16;
        cyc(3400);
        sm("freq", 16'h4800, 16'h4800);
        wr(AT, 32'h8);
        cyc(4);
        sm("freq", 16'h4800, 16'h0);
        wr(AT, 32'h0);
        cyc(3400);
        pv.filter_reset <= 2'h1;
        cyc(4);
        sm("freq", 16'h4800, 16'h0800);
        pv.filter_reset <= 2'h0;
        vper <= 12;
        cyc(3400);
        sm("freq", 16'h4800, 16'h4800);
        vper <= 13;
        cyc(3400);
        sm("freq", 16'h4800, 16'h0);
        $display("test freq done");
    endtask : t_freq

    initial begin
        presetn = 1'b0;
        pv = '0;
        vper = 13;
        vcnt = 0;
        vco = 1'b0;
        cycles = 0;
        failures = 0;
        num_checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tuning();
        t_live();
        t_latch();
        t_seed();
        t_freq();
        finish_test();
    end
endmodule : cts_regs_tb_top
